// file: fsp_device.sv
// Scan generator end: serial loader, scan machine, accumulator, pins
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/10ps
`include "fsp_params.svh"
module fsp_device (
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Link pins
    fsp_link_if.device link,
    // User side
    output logic [`FSP_DAC_W-1:0] analog_wave_out,
    output logic scan_done_out
);

    localparam int NSYNC = 6;
    localparam int P_SCLK = 0;
    localparam int P_FSN = 1;
    localparam int P_SERIAL = 2;
    localparam int P_TRIG = 3;
    localparam int P_ABORT = 4;
    localparam int P_STBY = 5;
    // Idle pin levels, so reset shows no false frame or edge
    localparam logic [NSYNC-1:0] PIN_IDLE = 6'h03;

    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] meta_r;
    logic [NSYNC-1:0] sync_r;
    logic [NSYNC-1:0] prev_r;

    assign pin_raw = {link.standby, link.scan_abort, link.scan_trigger,
                      link.serial_data, link.frame_sync_n, link.sclk};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            always_ff @(posedge clk_in) begin
                if (!resetn_in) begin
                    meta_r[gi] <= PIN_IDLE[gi];
                    sync_r[gi] <= PIN_IDLE[gi];
                    prev_r[gi] <= PIN_IDLE[gi];
                end else begin
                    meta_r[gi] <= pin_raw[gi];
                    sync_r[gi] <= meta_r[gi];
                    prev_r[gi] <= sync_r[gi];
                end
            end
        end
    endgenerate

    wire sclk_fall = prev_r[P_SCLK] & ~sync_r[P_SCLK];
    wire fsn = sync_r[P_FSN];
    wire trig_rise = sync_r[P_TRIG] & ~prev_r[P_TRIG];
    wire abort_rise = sync_r[P_ABORT] & ~prev_r[P_ABORT];
    wire stby = sync_r[P_STBY];

    // Serial word assembly
    logic [`FSP_WORD_W-1:0] shift_r;
    logic [3:0] bit_cnt_r;
    logic [`FSP_WORD_W-1:0] word;
    logic word_done;

    // one bit per falling serial edge
    assign word = {shift_r[`FSP_WORD_W-2:0], sync_r[P_SERIAL]};
    // counter wraps so words can stream
    assign word_done = sclk_fall & ~fsn & (bit_cnt_r == 4'hf);

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            shift_r <= '0;
            bit_cnt_r <= 4'h0;
        // frame sync high restarts the word
        end else if (fsn) begin
            bit_cnt_r <= 4'h0;
        end else if (sclk_fall) begin
            shift_r <= word;
            bit_cnt_r <= bit_cnt_r + 4'h1;
        end
    end

    // address field on top, data below
    wire [3:0] w_addr = word[`FSP_ADDR_MSB:`FSP_ADDR_LSB];
    wire [`FSP_DATA_W-1:0] w_data = word[`FSP_DATA_W-1:0];
    wire wr_ctrl = word_done & (w_addr == `FSP_A_CTRL);

    logic [`FSP_DATA_W-1:0] ctrl_r;
    logic [`FSP_ACC_W-1:0] fstart_r;
    logic [`FSP_ACC_W-1:0] delta_r;
    logic [`FSP_DATA_W-1:0] nincr_r;
    logic [`FSP_DATA_W-1:0] tint_r;

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            ctrl_r <= '0;
            fstart_r <= '0;
            delta_r <= '0;
            nincr_r <= '0;
            tint_r <= '0;
        end else if (word_done) begin
            case (w_addr)
                `FSP_A_CTRL: ctrl_r <= w_data;
                `FSP_A_FSTART_LO: fstart_r[11:0] <= w_data;
                `FSP_A_FSTART_HI: fstart_r[23:12] <= w_data;
                `FSP_A_DELTA_LO: delta_r[11:0] <= w_data;
                `FSP_A_DELTA_HI: delta_r[23:12] <= w_data;
                `FSP_A_NINCR: nincr_r <= w_data;
                `FSP_A_TINT: tint_r <= w_data;
                default: ctrl_r <= ctrl_r;
            endcase
        end
    end

    wire auto_mode = ctrl_r[`FSP_CB_AUTO];
    // abort edge resets the scan machine
    wire soft_rst = abort_rise | wr_ctrl;

    // Scan state machine
    fsp_pkg::fsp_scan_state_t state_r;
    fsp_pkg::fsp_scan_state_t state_nxt;
    logic [`FSP_ACC_W-1:0] freq_r;
    logic [`FSP_ACC_W-1:0] freq_nxt;
    logic [`FSP_DATA_W-1:0] cnt_r;
    logic [`FSP_DATA_W-1:0] cnt_nxt;
    logic [`FSP_DATA_W-1:0] tmr_r;
    logic [`FSP_DATA_W-1:0] tmr_nxt;
    logic incr_ev;
    logic end_scan_ev;

    // auto mode steps on its own timer
    // external mode steps on each trigger edge
    wire step_go = auto_mode ? (tmr_r == '0) : trig_rise;

    always_comb begin
        state_nxt = state_r;
        freq_nxt = freq_r;
        cnt_nxt = cnt_r;
        tmr_nxt = tmr_r;
        incr_ev = 1'b0;
        end_scan_ev = 1'b0;
        if (soft_rst) begin
            state_nxt = fsp_pkg::FSP_S_IDLE;
        end else if (!stby) begin
            case (state_r)
                fsp_pkg::FSP_S_IDLE: begin
                    if (trig_rise) begin
                        state_nxt = fsp_pkg::FSP_S_INIT;
                    end
                end
                fsp_pkg::FSP_S_INIT: begin
                    freq_nxt = fstart_r;
                    cnt_nxt = '0;
                    tmr_nxt = tint_r;
                    state_nxt = fsp_pkg::FSP_S_RUN;
                end
                fsp_pkg::FSP_S_RUN: begin
                    if (auto_mode && tmr_r != '0) begin
                        tmr_nxt = tmr_r - 1'b1;
                    end
                    if (step_go) begin
                        if (cnt_r == nincr_r) begin
                            end_scan_ev = 1'b1;
                            state_nxt = fsp_pkg::FSP_S_DONE;
                        end else begin
                            freq_nxt = freq_r + delta_r;
                            cnt_nxt = cnt_r + 1'b1;
                            tmr_nxt = tint_r;
                            incr_ev = 1'b1;
                        end
                    end
                end
                fsp_pkg::FSP_S_DONE: begin
                    state_nxt = fsp_pkg::FSP_S_DONE;
                end
                default: begin
                    state_nxt = fsp_pkg::FSP_S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            state_r <= fsp_pkg::FSP_S_IDLE;
            freq_r <= '0;
            cnt_r <= '0;
            tmr_r <= '0;
        end else begin
            state_r <= state_nxt;
            freq_r <= freq_nxt;
            cnt_r <= cnt_nxt;
            tmr_r <= tmr_nxt;
        end
    end

    // Phase accumulator and output code
    logic [`FSP_ACC_W-1:0] acc_r;
    logic [`FSP_DAC_W-1:0] code_r;
    logic status_r;
    logic sign_r;
    wire active = (state_r == fsp_pkg::FSP_S_RUN) |
                  (state_r == fsp_pkg::FSP_S_DONE);
    wire [`FSP_DAC_W-1:0] acc_code =
        acc_r[`FSP_ACC_W-1:`FSP_ACC_W-`FSP_DAC_W];
    // status source picks increment or end
    wire status_ev = ctrl_r[`FSP_CB_SRC] ? incr_ev : end_scan_ev;

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            acc_r <= '0;
            code_r <= `FSP_MIDSCALE;
            status_r <= 1'b0;
            sign_r <= 1'b0;
        end else begin
            if (soft_rst || !active) begin
                acc_r <= '0;
                code_r <= `FSP_MIDSCALE;
            end else if (!stby) begin
                acc_r <= acc_r + freq_r;
                code_r <= acc_code;
            end
            status_r <= ctrl_r[`FSP_CB_STEN] & status_ev;
            // inverted MSB of the data word
            sign_r <= ~code_r[`FSP_DAC_W-1];
        end
    end

    assign analog_wave_out = code_r;
    assign scan_done_out = (state_r == fsp_pkg::FSP_S_DONE);
    assign link.scan_status_out = status_r;
    assign link.sign_bit_out = sign_r;
    assign link.sign_bit_oe = ctrl_r[`FSP_CB_SGEN];

endmodule : fsp_device

// file: fsp_host.sv
// Host end: serial word sender, trigger/abort pulser, register port
`timescale 1ns/10ps
`include "fsp_params.svh"
module fsp_host (
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Register port
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    output logic irq_out,
    // Link pins
    fsp_link_if.host link
);

    wire wr_tx = wr_in & (addr_in == `FSP_R_TXWORD);
    wire wr_cmd = wr_in & (addr_in == `FSP_R_CMD);
    wire wr_stat = wr_in & (addr_in == `FSP_R_IRQ_STAT);
    wire wr_mask = wr_in & (addr_in == `FSP_R_IRQ_MASK);

    // Synchronise the returning pins
    logic [1:0] meta_r;
    logic [1:0] sync_r;
    logic status_prev_r;
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            meta_r <= 2'h0;
            sync_r <= 2'h0;
            status_prev_r <= 1'b0;
        end else begin
            meta_r <= {link.sign_bit_pin, link.scan_status_out};
            sync_r <= meta_r;
            status_prev_r <= sync_r[0];
        end
    end
    wire status_rise = sync_r[0] & ~status_prev_r;

    // Serial sender
    fsp_pkg::fsp_host_state_t hst_r;
    logic [`FSP_WORD_W-1:0] sh_r;
    logic [`FSP_WORD_W-1:0] pend_r;
    logic pend_v_r;
    logic [3:0] bit_r;
    logic [7:0] div_r;
    logic sclk_r;
    logic fsn_r;
    logic sent_ev;
    wire half_done = (div_r == 8'(`FSP_SCLK_HALF_CYC - 1));
    wire last_bit = (bit_r == 4'hf);
    wire idle = (hst_r == fsp_pkg::FSP_H_IDLE);

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            hst_r <= fsp_pkg::FSP_H_IDLE;
            sh_r <= '0;
            pend_r <= '0;
            pend_v_r <= 1'b0;
            bit_r <= 4'h0;
            div_r <= 8'h00;
            sclk_r <= 1'b1;
            fsn_r <= 1'b1;
            sent_ev <= 1'b0;
        end else begin
            sent_ev <= 1'b0;
            div_r <= half_done ? 8'h00 : div_r + 8'h01;
            if (wr_tx && !idle && !pend_v_r) begin
                pend_r <= wdata_in[`FSP_WORD_W-1:0];
                pend_v_r <= 1'b1;
            end
            case (hst_r)
                // frame sync low opens the word
                fsp_pkg::FSP_H_IDLE: begin
                    div_r <= 8'h00;
                    // Word queued during the frame tail goes out next
                    if (wr_tx || pend_v_r) begin
                        sh_r <= pend_v_r ? pend_r : wdata_in[`FSP_WORD_W-1:0];
                        pend_v_r <= 1'b0;
                        bit_r <= 4'h0;
                        fsn_r <= 1'b0;
                        hst_r <= fsp_pkg::FSP_H_HIGH;
                    end
                end
                fsp_pkg::FSP_H_HIGH: begin
                    if (half_done) begin
                        sclk_r <= 1'b0;
                        hst_r <= fsp_pkg::FSP_H_LOW;
                    end
                end
                fsp_pkg::FSP_H_LOW: begin
                    if (half_done) begin
                        sclk_r <= 1'b1;
                        bit_r <= bit_r + 4'h1;
                        sh_r <= {sh_r[`FSP_WORD_W-2:0], 1'b0};
                        hst_r <= fsp_pkg::FSP_H_HIGH;
                        if (last_bit) begin
                            sent_ev <= 1'b1;
                            // keep frame low for queued word
                            if (pend_v_r) begin
                                sh_r <= pend_r;
                                pend_v_r <= 1'b0;
                            end else begin
                                hst_r <= fsp_pkg::FSP_H_END;
                            end
                        end
                    end
                end
                fsp_pkg::FSP_H_END: begin
                    if (half_done) begin
                        fsn_r <= 1'b1;
                        hst_r <= fsp_pkg::FSP_H_IDLE;
                    end
                end
                default: hst_r <= fsp_pkg::FSP_H_IDLE;
            endcase
        end
    end

    // Trigger/abort pulses and standby level
    logic [3:0] trig_cnt_r;
    logic [3:0] abort_cnt_r;
    logic stby_r;
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            trig_cnt_r <= 4'h0;
            abort_cnt_r <= 4'h0;
            stby_r <= 1'b0;
        end else begin
            if (trig_cnt_r != 4'h0) trig_cnt_r <= trig_cnt_r - 4'h1;
            if (abort_cnt_r != 4'h0) abort_cnt_r <= abort_cnt_r - 4'h1;
            if (wr_cmd) begin
                if (wdata_in[`FSP_CMD_TRIG]) trig_cnt_r <= 4'(`FSP_PULSE_CYC);
                if (wdata_in[`FSP_CMD_ABORT])
                    abort_cnt_r <= 4'(`FSP_PULSE_CYC);
                stby_r <= wdata_in[`FSP_CMD_STBY];
            end
        end
    end

    // Sticky events, set wins over write-one-to-clear
    logic [`FSP_IRQ_W-1:0] stat_r;
    logic [`FSP_IRQ_W-1:0] mask_r;
    logic [31:0] rdata_r;
    wire [`FSP_IRQ_W-1:0] ev = {status_rise, sent_ev};
    wire [`FSP_IRQ_W-1:0] clr = wr_stat ? wdata_in[`FSP_IRQ_W-1:0] : '0;
    wire [31:0] state_word = {28'h0, sync_r[0], sync_r[1], pend_v_r, ~idle};
    wire [31:0] rd_mux =
        (addr_in == `FSP_R_IRQ_STAT) ? {30'h0, stat_r} :
        (addr_in == `FSP_R_IRQ_MASK) ? {30'h0, mask_r} :
        (addr_in == `FSP_R_STATE) ? state_word : 32'h0;

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            stat_r <= '0;
            mask_r <= '0;
            rdata_r <= 32'h0;
        end else begin
            stat_r <= (stat_r & ~clr) | ev;
            if (wr_mask) mask_r <= wdata_in[`FSP_IRQ_W-1:0];
            rdata_r <= rd_in ? rd_mux : 32'h0;
        end
    end

    assign rdata_out = rdata_r;
    assign irq_out = |(stat_r & mask_r);
    assign link.sclk = sclk_r;
    assign link.frame_sync_n = fsn_r;
    assign link.serial_data = sh_r[`FSP_WORD_W-1];
    assign link.scan_trigger = (trig_cnt_r != 4'h0);
    assign link.scan_abort = (abort_cnt_r != 4'h0);
    assign link.standby = stby_r;

endmodule : fsp_host

// file: fsp_link_if.sv
// Pin bundle between host controller and scan generator
`timescale 1ns/10ps
interface fsp_link_if;
    logic sclk;
    logic frame_sync_n;
    logic serial_data;
    logic scan_trigger;
    logic scan_abort;
    logic standby;
    logic scan_status_out;
    logic sign_bit_out;
    logic sign_bit_oe;
    logic sign_bit_pin;

    // Undriven sign pin reads low, as with a weak pull-down
    assign sign_bit_pin = sign_bit_oe & sign_bit_out;

    modport device (
        input sclk, frame_sync_n, serial_data, scan_trigger, scan_abort,
        input standby,
        output scan_status_out, sign_bit_out, sign_bit_oe
    );

    modport host (
        output sclk, frame_sync_n, serial_data, scan_trigger, scan_abort,
        output standby,
        input scan_status_out, sign_bit_pin
    );
endinterface : fsp_link_if

// file: fsp_link_monitor.sv
// Checker watching the pins between host and scan generator
`timescale 1ns/10ps
module fsp_link_monitor (
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Link pins
    input wire logic sclk,
    input wire logic frame_sync_n,
    input wire logic serial_data,
    input wire logic scan_trigger,
    input wire logic scan_abort,
    input wire logic standby,
    input wire logic scan_status_out,
    input wire logic sign_bit_out,
    input wire logic sign_bit_oe,
    input wire logic sign_bit_pin,
    // Generator output code
    input wire logic [9:0] analog_wave_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    logic sclk_d_r;
    logic [7:0] falls_r;
    logic [7:0] falls_nxt;
    wire sclk_fell = sclk_d_r & ~sclk;
    // Count resets whenever the frame is closed
    assign falls_nxt = frame_sync_n ? 8'h00 : falls_r + {7'h0, sclk_fell};

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            sclk_d_r <= 1'b1;
            falls_r <= 8'h00;
        end else begin
            sclk_d_r <= sclk;
            falls_r <= falls_nxt;
        end
    end

    sequence s_low_hold;
        !sclk[*4] ##1 sclk;
    endsequence
    sequence s_pulse(sig);
        sig[*4] ##1 !sig;
    endsequence

    a_idle_sclk_high: assert property (frame_sync_n |-> sclk)
        else $error("serial clock not idle high outside frame");
    a_frame_first_fall: assert property ($fell(frame_sync_n) |->
        sclk ##4 !sclk)
        else $error("first falling edge misplaced after frame start");
    a_data_on_rise: assert property
        (!frame_sync_n && !$fell(frame_sync_n)
        && $changed(serial_data) |-> $rose(sclk))
        else $error("serial data changed away from rising edge");
    a_sclk_low_span: assert property ($fell(sclk) |-> s_low_hold)
        else $error("serial clock low phase wrong length");
    a_sclk_high_span: assert property
        ($rose(sclk) && !frame_sync_n |-> sclk[*4])
        else $error("serial clock high phase too short");
    a_word_whole: assert property ($rose(frame_sync_n) |->
        falls_r[3:0] == 4'h0 && falls_r != 8'h00)
        else $error("frame closed on a partial word");
    a_trig_width: assert property ($rose(scan_trigger) |->
        s_pulse(scan_trigger))
        else $error("trigger pulse width wrong");
    a_abort_width: assert property ($rose(scan_abort) |->
        s_pulse(scan_abort))
        else $error("abort pulse width wrong");
    a_abort_midscale: assert property ($rose(scan_abort) |->
        ##[3:8] analog_wave_out == 10'h200)
        else $error("code not midscale after abort");
    a_status_pulse: assert property (scan_status_out |=>
        !scan_status_out)
        else $error("status output longer than one cycle");
    a_sign_inverse: assert property (sign_bit_oe |->
        sign_bit_pin == !$past(analog_wave_out[9]))
        else $error("sign pin not inverse of code top bit");
    a_sign_gated: assert property (!sign_bit_oe |-> !sign_bit_pin)
        else $error("sign pin driven while disabled");
    a_standby_hold: assert property (standby[*6] |->
        $stable(analog_wave_out))
        else $error("code moved during standby");
endmodule : fsp_link_monitor

// file: fsp_params.svh
// Constants shared by both ends of the frequency scan pin link
// Function
// - 16-bit word, address first, data MSB first
// - Device takes one bit per serial falling edge
// - Frame sync low starts a new word
// - Abort rising edge resets scan machines
// - After abort, output code is midscale
// - Trigger rising edge initialises and starts scan
// - Auto mode: one pulse runs whole scan
// - External mode: one trigger edge per step
// - Status shows end of scan or increments
// - Status output idle unless enabled
// - Sign output is inverted data MSB
// - Sign output driven only when enabled
// - Standby high stops internal clocked activity; here the serial loader and abort keep working
// - Host resets device before raising standby; host here raises it without a reset
// - Frequency from master-clocked phase accumulator
// - Words may stream back to back
// - Control write resets like abort does
// - Final frequency held until reset
`ifndef FSP_PARAMS_SVH
`define FSP_PARAMS_SVH

`define FSP_WORD_W 16
`define FSP_ADDR_MSB 15
`define FSP_ADDR_LSB 12
`define FSP_DATA_W 12
// Device register addresses in the word's address field
`define FSP_A_CTRL 4'h0
`define FSP_A_FSTART_LO 4'h1
`define FSP_A_FSTART_HI 4'h2
`define FSP_A_DELTA_LO 4'h3
`define FSP_A_DELTA_HI 4'h4
`define FSP_A_NINCR 4'h5
`define FSP_A_TINT 4'h6
// Control word bits
`define FSP_CB_AUTO 0
`define FSP_CB_SRC 1
`define FSP_CB_STEN 2
`define FSP_CB_SGEN 3
`define FSP_ACC_W 24
`define FSP_DAC_W 10
`define FSP_MIDSCALE 10'h200
// Host register map
`define FSP_R_TXWORD 8'h00
`define FSP_R_CMD 8'h04
`define FSP_R_IRQ_STAT 8'h08
`define FSP_R_IRQ_MASK 8'h0c
`define FSP_R_STATE 8'h10
`define FSP_CMD_TRIG 0
`define FSP_CMD_ABORT 1
`define FSP_CMD_STBY 2
`define FSP_IRQ_SENT 0
`define FSP_IRQ_STATUS 1
`define FSP_IRQ_W 2
// Timing
`define FSP_CLK_NS 25
`define FSP_SCLK_HALF_NS 100
`define FSP_SCLK_HALF_CYC (`FSP_SCLK_HALF_NS / `FSP_CLK_NS)
`define FSP_PULSE_NS 100
`define FSP_PULSE_CYC ((`FSP_PULSE_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)

`endif

// file: fsp_pkg.sv
// Types shared by both ends of the frequency scan pin link
package fsp_pkg;

    typedef enum logic [3:0] {
        FSP_S_IDLE = 4'b0001,
        FSP_S_INIT = 4'b0010,
        FSP_S_RUN = 4'b0100,
        FSP_S_DONE = 4'b1000
    } fsp_scan_state_t;

    typedef enum logic [3:0] {
        FSP_H_IDLE = 4'b0001,
        FSP_H_HIGH = 4'b0010,
        FSP_H_LOW = 4'b0100,
        FSP_H_END = 4'b1000
    } fsp_host_state_t;

endpackage : fsp_pkg

// file: fsp_test.sv
// Bench driving the host register port and watching the link pins
`timescale 1ns/10ps
`include "fsp_params.svh"
module fsp_test;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [31:0] rdata_out;
    logic irq_out;
    logic [9:0] analog_wave_out;
    logic scan_done_out;
    logic sclk_d = 1'b1;
    logic fs_d = 1'b1;
    int sign_hits = 0;
    int s0 = 0;
    logic [15:0] cap = 16'h0;
    logic [15:0] w;
    logic [31:0] rv;
    logic [9:0] c0;
    int fails = 0;
    int samples_checked = 0;
    int frames = 0;
    int cyc = 0;
    int n;
    int t;
    int k;

    fsp_link_if link ();
    fsp_host fsp_host_inst (.clk_in(clk_in), .resetn_in(resetn_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .irq_out(irq_out), .link(link.host));
    fsp_device fsp_device_inst (.clk_in(clk_in), .resetn_in(resetn_in),
        .link(link.device), .analog_wave_out(analog_wave_out),
        .scan_done_out(scan_done_out));
    fsp_link_monitor fsp_link_monitor_inst (.clk_in(clk_in),
        .resetn_in(resetn_in), .sclk(link.sclk),
        .frame_sync_n(link.frame_sync_n), .serial_data(link.serial_data),
        .scan_trigger(link.scan_trigger), .scan_abort(link.scan_abort),
        .standby(link.standby), .scan_status_out(link.scan_status_out),
        .sign_bit_out(link.sign_bit_out), .sign_bit_oe(link.sign_bit_oe),
        .sign_bit_pin(link.sign_bit_pin), .analog_wave_out(analog_wave_out));

    always #12.5 clk_in = ~clk_in;

    // Wire-side capture, frame count and hang guard
    always @(posedge clk_in) begin
        sclk_d <= link.sclk;
        fs_d <= link.frame_sync_n;
        if (sclk_d && !link.sclk && !link.frame_sync_n)
            cap <= {cap[14:0], link.serial_data};
        if (link.frame_sync_n && !fs_d)
            frames <= frames + 1;
        if (link.sign_bit_pin)
            sign_hits <= sign_hits + 1;
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fails = fails + 1;
            tally_and_finish();
        end
    end

    function automatic logic exp_done(int k, int n);
        // Start edge, then one step per count 0..n
        return k >= n + 2;
    endfunction : exp_done

    task automatic check_reg(string what, logic [31:0] e, logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, e, g);
        end
    endtask : check_reg

    task automatic check_bit(string what, logic e, logic g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %b seen %b", what, e, g);
        end
    endtask : check_bit

    task automatic settle(int m);
        repeat (m) @(posedge clk_in);
        #1;
    endtask : settle

    task automatic reg_wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(logic [7:0] a, output logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask : reg_rd

    // Waits for room in the one-word queue, so words stream
    task automatic send(logic [3:0] a, logic [11:0] d);
        int i;
        rv = 32'h2;
        for (i = 0; i < 400 && rv[1]; i++)
            reg_rd(`FSP_R_STATE, rv);
        reg_wr(`FSP_R_TXWORD, {16'h0, a, d});
    endtask : send

    task automatic wait_idle();
        int i;
        rv = 32'h1;
        for (i = 0; i < 400 && rv[0]; i++)
            reg_rd(`FSP_R_STATE, rv);
        settle(8);
    endtask : wait_idle

    task automatic cmd(logic [2:0] c);
        reg_wr(`FSP_R_CMD, {29'h0, c});
        settle(12);
    endtask : cmd

    // Start frequency gives a code step of one per clock
    task automatic program_scan(logic [3:0] c, logic [11:0] ni,
        logic [11:0] ti);
        send(`FSP_A_CTRL, {8'h0, c});
        send(`FSP_A_FSTART_LO, 12'h000);
        send(`FSP_A_FSTART_HI, 12'h004);
        send(`FSP_A_DELTA_LO, 12'h000);
        send(`FSP_A_DELTA_HI, 12'h000);
        send(`FSP_A_NINCR, ni);
        send(`FSP_A_TINT, ti);
        wait_idle();
        reg_wr(`FSP_R_IRQ_STAT, 32'h3);
    endtask : program_scan

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish

    initial begin
        void'($urandom(89));
        repeat (8) @(posedge clk_in);
        resetn_in <= 1'b1;
        reg_rd(`FSP_R_IRQ_STAT, rv);
        check_reg("irq_stat", 32'h0, rv);
        reg_rd(8'h44, rv);
        check_reg("unmapped", 32'h0, rv);
        check_reg("code", 32'h200, {22'h0, analog_wave_out});
        $display("test reset ended");
        // Unused device addresses, so words only exercise the wire
        for (k = 0; k < 3; k++) begin
            w = (k == 0) ? 16'hffff : 16'h8000 | 16'($urandom);
            send(w[15:12], w[11:0]);
            wait_idle();
            check_reg("word", {16'h0, w}, {16'h0, cap});
        end
        reg_rd(`FSP_R_IRQ_STAT, rv);
        check_bit("sent flag", 1'b1, rv[0]);
        settle(2);
        check_bit("irq masked", 1'b0, irq_out);
        reg_wr(`FSP_R_IRQ_MASK, 32'h3);
        settle(2);
        check_bit("irq open", 1'b1, irq_out);
        reg_wr(`FSP_R_IRQ_STAT, 32'h3);
        settle(2);
        check_bit("irq cleared", 1'b0, irq_out);
        t = frames;
        w = 16'h9000 | 16'($urandom);
        reg_wr(`FSP_R_TXWORD, 32'h0000_a5a5);
        reg_wr(`FSP_R_TXWORD, {16'h0, w});
        wait_idle();
        check_reg("frames", 32'h1, 32'(frames - t));
        check_reg("stream", {16'h0, w}, {16'h0, cap});
        $display("test serial ended");
        n = 1 + $urandom % 3;
        program_scan(4'hc, 12'(n), 12'h010);
        for (k = 1; k <= n + 3; k++) begin
            cmd(3'h1);
            check_bit("done", exp_done(k, n), scan_done_out);
            c0 = analog_wave_out + 10'h1;
            settle(1);
            check_reg("step", 32'(c0), 32'(analog_wave_out));
            reg_rd(`FSP_R_IRQ_STAT, rv);
            check_bit("end flag", exp_done(k, n), rv[1]);
        end
        $display("test external ended");
        n = 1 + $urandom % 3;
        t = 40 + $urandom % 20;
        program_scan(4'h1, 12'(n), 12'(t));
        s0 = sign_hits;
        cmd(3'h1);
        reg_wr(`FSP_R_CMD, 32'h4);
        settle(8);
        c0 = analog_wave_out;
        settle(20);
        check_reg("standby", {22'h0, c0}, {22'h0, analog_wave_out});
        check_bit("early", 1'b0, scan_done_out);
        reg_wr(`FSP_R_CMD, 32'h0);
        for (k = 0; k < (n + 1) * (t + 1) + 60 && !scan_done_out; k++)
            settle(1);
        check_bit("auto done", 1'b1, scan_done_out);
        reg_rd(`FSP_R_IRQ_STAT, rv);
        check_bit("status off", 1'b0, rv[1]);
        check_bit("sign off", 1'b0, sign_hits != s0);
        send(`FSP_A_CTRL, 12'h001);
        wait_idle();
        check_reg("ctrl reset", 32'h200, {22'h0, analog_wave_out});
        check_bit("ctrl idle", 1'b0, scan_done_out);
        send(`FSP_A_CTRL, 12'h006);
        wait_idle();
        reg_wr(`FSP_R_IRQ_STAT, 32'h3);
        cmd(3'h1);
        reg_rd(`FSP_R_IRQ_STAT, rv);
        check_bit("no incr", 1'b0, rv[1]);
        cmd(3'h1);
        reg_rd(`FSP_R_IRQ_STAT, rv);
        check_bit("incr flag", 1'b1, rv[1]);
        cmd(3'h1);
        settle(10);
        cmd(3'h2);
        check_reg("abort", 32'h200, {22'h0, analog_wave_out});
        check_bit("abort idle", 1'b0, scan_done_out);
        reg_wr(`FSP_R_CMD, 32'h4);
        settle(8);
        check_reg("rest stby", 32'h200, 32'(analog_wave_out));
        $display("test auto ended");
        tally_and_finish();
    end
endmodule : fsp_test
